// ### hw/ovds_ctrl.v
`include "ovds_regs.vh"
`default_nettype none

module ovds_ctrl (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [`OVDS_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // analog comparators
    input wire ov_comp_in,
    input wire desat_comp_in,
    input wire desat_watchdog_in,
    output reg [7:0] ov_level_code,
    output reg desat_input_select,
    output reg [7:0] desat_offset_trim,
    // power stage
    input wire pwm_primary_in,
    input wire pwm_secondary_in,
    output reg primary_gate_drive,
    output reg secondary_gate_drive,
    output reg desat_pwm_out,
    output reg desat_pwm_reset,
    // interrupt
    output reg irq
);

    reg ov_protect_enable_q;
    reg ov_rise_irq_select_q;
    reg ov_fall_irq_select_q;
    reg desat_watchdog_enable_q;
    reg desat_reserved_q;
    reg desat_polarity_q;
    reg desat_pwm_enable_q;
    reg desat_rise_irq_select_q;
    reg desat_fall_irq_select_q;
    reg [1:0] irq_status_q;
    reg [1:0] irq_mask_q;

    // channel 0 overvoltage, 1 desat, 2 watchdog
    wire [2:0] comp_raw;
    wire [2:0] comp_sync;
    wire [2:0] comp_prev;

    assign comp_raw[0] = ov_comp_in;
    assign comp_raw[1] = desat_comp_in;
    assign comp_raw[2] = desat_watchdog_in;

    // two-flop synchronisers; stage 1 read only by stage 2
    // reset low matches the idle comparators, so no false edge
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_sync
            reg s1_q;
            reg s2_q;
            reg prev_q;

            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    s1_q <= comp_raw[ch];
                    s2_q <= s1_q;
                    prev_q <= s2_q;
                end
            end

            assign comp_sync[ch] = s2_q;
            assign comp_prev[ch] = prev_q;
        end
    endgenerate

    wire ov_sync = comp_sync[0];
    wire ov_last = comp_prev[0];
    wire ds_sync = comp_sync[1];
    wire ds_last = comp_prev[1];
    // watchdog is a level; its previous sample is left unused
    wire wd_sync = comp_sync[2];
    wire wd_last = comp_prev[2];

    // comparator high means sense above reference
    wire ov_now = ov_sync;
    // polarity applied before edges and status
    // so a polarity write alone raises no edge
    wire ds_now = ds_sync ^ desat_polarity_q;
    wire ds_was = ds_last ^ desat_polarity_q;

    wire ov_rise = ov_now & ~ov_last;
    wire ov_fall = ~ov_now & ov_last;
    wire ds_rise = ds_now & ~ds_was;
    wire ds_fall = ~ds_now & ds_was;

    // no enable or mask qualifies the set terms
    wire ov_evt = (ov_rise & ov_rise_irq_select_q)
        | (ov_fall & ov_fall_irq_select_q);
    wire ds_evt = (ds_rise & desat_rise_irq_select_q)
        | (ds_fall & desat_fall_irq_select_q);

    wire wr_ovc = reg_wr && (reg_addr == `OVDS_OFS_OV_CONTROL);
    wire wr_lvl = reg_wr && (reg_addr == `OVDS_OFS_OV_LEVEL);
    wire wr_dsc = reg_wr && (reg_addr == `OVDS_OFS_DESAT_CONTROL);
    wire wr_trm = reg_wr && (reg_addr == `OVDS_OFS_DESAT_TRIM);
    wire wr_sts = reg_wr && (reg_addr == `OVDS_OFS_IRQ_STATUS);
    wire wr_msk = reg_wr && (reg_addr == `OVDS_OFS_IRQ_MASK);

    // set wins over write-one-to-clear
    wire [1:0] irq_status_d = (irq_status_q & ~(wr_sts ? reg_wdata[1:0] : 2'h0))
        | {ds_evt, ov_evt};

    // overvoltage control bits; status bit is not stored
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ov_protect_enable_q <= 1'b0;
            ov_rise_irq_select_q <= 1'b0;
            ov_fall_irq_select_q <= 1'b0;
        end else if (wr_ovc) begin
            ov_protect_enable_q <= reg_wdata[`OVDS_OV_PROTECT_EN];
            ov_rise_irq_select_q <= reg_wdata[`OVDS_OV_RISE_SEL];
            ov_fall_irq_select_q <= reg_wdata[`OVDS_OV_FALL_SEL];
        end
    end

    // level code straight to the reference dac
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ov_level_code <= `OVDS_RST_LEVEL;
        end else if (wr_lvl) begin
            ov_level_code <= reg_wdata;
        end
    end

    // desat control bits; reserved bit kept read/write
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            desat_input_select <= 1'b0;
            desat_watchdog_enable_q <= 1'b0;
            desat_reserved_q <= 1'b0;
            desat_polarity_q <= 1'b0;
            desat_pwm_enable_q <= 1'b0;
            desat_rise_irq_select_q <= 1'b0;
            desat_fall_irq_select_q <= 1'b0;
        end else if (wr_dsc) begin
            desat_input_select <= reg_wdata[`OVDS_DS_INPUT_SEL];
            desat_watchdog_enable_q <= reg_wdata[`OVDS_DS_WDOG_EN];
            desat_reserved_q <= reg_wdata[`OVDS_DS_RESERVED];
            desat_polarity_q <= reg_wdata[`OVDS_DS_POLARITY];
            desat_pwm_enable_q <= reg_wdata[`OVDS_DS_PWM_EN];
            desat_rise_irq_select_q <= reg_wdata[`OVDS_DS_RISE_SEL];
            desat_fall_irq_select_q <= reg_wdata[`OVDS_DS_FALL_SEL];
        end
    end

    // trim is only held; loading it is up to firmware
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            desat_offset_trim <= `OVDS_RST_TRIM;
        end else if (wr_trm) begin
            desat_offset_trim <= reg_wdata;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= `OVDS_RST_IRQ;
        end else if (wr_msk) begin
            irq_mask_q <= reg_wdata[1:0];
        end
    end

    // sticky flags; mask never stops a set
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_status_q <= `OVDS_RST_IRQ;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    // read mux; ov and desat status bits ignore writes, irq status bits clear on a written one
    reg [7:0] rdata_d;
    always @* begin
        rdata_d = 8'h00;
        case (reg_addr)
            `OVDS_OFS_OV_CONTROL: begin
                rdata_d[`OVDS_OV_PROTECT_EN] = ov_protect_enable_q;
                rdata_d[`OVDS_OV_STATUS] = ov_now;
                rdata_d[`OVDS_OV_RISE_SEL] = ov_rise_irq_select_q;
                rdata_d[`OVDS_OV_FALL_SEL] = ov_fall_irq_select_q;
            end
            `OVDS_OFS_OV_LEVEL: begin
                rdata_d = ov_level_code;
            end
            `OVDS_OFS_DESAT_CONTROL: begin
                rdata_d[`OVDS_DS_INPUT_SEL] = desat_input_select;
                rdata_d[`OVDS_DS_WDOG_EN] = desat_watchdog_enable_q;
                rdata_d[`OVDS_DS_RESERVED] = desat_reserved_q;
                rdata_d[`OVDS_DS_POLARITY] = desat_polarity_q;
                rdata_d[`OVDS_DS_PWM_EN] = desat_pwm_enable_q;
                rdata_d[`OVDS_DS_STATUS] = ds_now;
                rdata_d[`OVDS_DS_RISE_SEL] = desat_rise_irq_select_q;
                rdata_d[`OVDS_DS_FALL_SEL] = desat_fall_irq_select_q;
            end
            `OVDS_OFS_DESAT_TRIM: begin
                rdata_d = desat_offset_trim;
            end
            `OVDS_OFS_IRQ_STATUS: begin
                rdata_d[1:0] = irq_status_q;
            end
            `OVDS_OFS_IRQ_MASK: begin
                rdata_d[1:0] = irq_mask_q;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // outputs registered; one cycle of added drive latency accepted
    // read data only in the cycle after the strobe
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // safe state overrides the pwm core while enabled and overvoltage is sensed
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            primary_gate_drive <= 1'b0;
            secondary_gate_drive <= 1'b0;
        end else if (ov_protect_enable_q && ov_now) begin
            primary_gate_drive <= 1'b0;
            secondary_gate_drive <= 1'b1;
        end else begin
            primary_gate_drive <= pwm_primary_in;
            secondary_gate_drive <= pwm_secondary_in;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            desat_pwm_out <= 1'b0;
        end else begin
            desat_pwm_out <= desat_pwm_enable_q & ds_now;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            desat_pwm_reset <= 1'b0;
        end else begin
            desat_pwm_reset <= desat_watchdog_enable_q & wd_sync;
        end
    end

    // from next status so irq rises with the flag
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_d & irq_mask_q);
        end
    end

endmodule

`default_nettype wire

// ### hw/ovds_regs.vh
`ifndef OVDS_REGS_VH
`define OVDS_REGS_VH

// register indices (byte address = index)
`define OVDS_ADDR_W 9
`define OVDS_OFS_OV_CONTROL 9'h0C0
`define OVDS_OFS_OV_LEVEL 9'h0C1
`define OVDS_OFS_DESAT_CONTROL 9'h0C2
`define OVDS_OFS_DESAT_TRIM 9'h196
`define OVDS_OFS_IRQ_STATUS 9'h0C3
`define OVDS_OFS_IRQ_MASK 9'h0C4

// output_ov_control fields
`define OVDS_OV_FALL_SEL 0
`define OVDS_OV_RISE_SEL 1
`define OVDS_OV_STATUS 2
`define OVDS_OV_PROTECT_EN 3

// desat_control fields
`define OVDS_DS_FALL_SEL 0
`define OVDS_DS_RISE_SEL 1
`define OVDS_DS_STATUS 2
`define OVDS_DS_PWM_EN 3
`define OVDS_DS_POLARITY 4
`define OVDS_DS_RESERVED 5
`define OVDS_DS_WDOG_EN 6
`define OVDS_DS_INPUT_SEL 7

// interrupt status / mask fields
`define OVDS_IRQ_OV 0
`define OVDS_IRQ_DESAT 1

// reset values
`define OVDS_RST_CONTROL 8'h00
`define OVDS_RST_LEVEL 8'h00
`define OVDS_RST_TRIM 8'h00
`define OVDS_RST_IRQ 2'h0

`endif

// ### verif/ovds_checker.sv
`include "ovds_regs.vh"
`default_nettype none
module ovds_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [`OVDS_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // comparator side
    input wire logic ov_comp_in,
    input wire logic [7:0] ov_level_code,
    input wire logic primary_gate_drive,
    input wire logic secondary_gate_drive,
    input wire logic desat_pwm_out,
    input wire logic desat_pwm_reset,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ovc_q, dsc_q, msk_q;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // shadows of the writes, so no body signal is needed
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ovc_q <= 8'h00;
            dsc_q <= 8'h00;
            msk_q <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == `OVDS_OFS_OV_CONTROL) ovc_q <= reg_wdata;
            if (reg_addr == `OVDS_OFS_DESAT_CONTROL) dsc_q <= reg_wdata;
            if (reg_addr == `OVDS_OFS_IRQ_MASK) msk_q <= reg_wdata;
        end
    end
    a_ov_safe: assert property ((ovc_q[3] && ov_comp_in) [*5]
        |-> secondary_gate_drive && !primary_gate_drive) else $error("ov drive");
    a_ov_rise: assert property ($rose(ov_comp_in) && ovc_q[1] && msk_q[0]
        ##1 ov_comp_in [*3] |-> ##[0:3] irq) else $error("ov rise");
    a_ov_fall: assert property ($fell(ov_comp_in) && ovc_q[0] && msk_q[0]
        ##1 !ov_comp_in [*3] |-> ##[0:3] irq) else $error("ov fall");
    a_level_load: assert property (reg_wr && reg_addr == `OVDS_OFS_OV_LEVEL
        |=> ov_level_code == $past(reg_wdata)) else $error("level");
    a_wdog_gate: assert property ((!dsc_q[6]) [*3] |-> !desat_pwm_reset)
        else $error("wdog");
    a_pwm_gate: assert property ((!dsc_q[3]) [*3] |-> !desat_pwm_out)
        else $error("pwm gate");
    a_irq_masked: assert property ((msk_q[1:0] == 2'h0) [*2] |-> !irq)
        else $error("irq mask");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("rdata");
endmodule
bind ovds_ctrl ovds_checker i_checker (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ov_comp_in(ov_comp_in), .ov_level_code(ov_level_code),
    .primary_gate_drive(primary_gate_drive), .secondary_gate_drive(secondary_gate_drive),
    .desat_pwm_out(desat_pwm_out), .desat_pwm_reset(desat_pwm_reset), .irq(irq));
`default_nettype wire

// ### verif/ovds_analog_model.sv
`default_nettype none
module ovds_analog_model (
    // levels as codes
    input wire logic [7:0] sense,
    input wire logic [7:0] pin,
    input wire logic wdog,
    // from the block
    input wire logic [7:0] level,
    input wire logic sel,
    // comparator outputs
    output logic ov_out,
    output logic ds_out,
    output logic wdog_out
);
    timeunit 1ns;
    timeprecision 1ns;
    assign ov_out = sense > level;
    // bandgap code sits above the fixed minus input
    assign ds_out = (sel ? 8'h80 : pin) > 8'h40;
    assign wdog_out = wdog;
endmodule
`default_nettype wire

// ### verif/test_ovds_ctrl.sv
`default_nettype none
module test_ovds_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, wr, rd, wdog, pp, ps, ovc, dsc, wdr, irq, pd, sd, dso, dsr, dsel;
    logic [8:0] addr;
    logic [7:0] wd, rdat, lvl, trim, sense, pin, code;
    logic [31:0] rnd = 32'h3756;
    int n_fail = 0, n_checks = 0, cyc = 0;
    ovds_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .ov_comp_in(ovc), .desat_comp_in(dsc),
        .desat_watchdog_in(wdr), .ov_level_code(lvl), .desat_input_select(dsel),
        .desat_offset_trim(trim), .pwm_primary_in(pp), .pwm_secondary_in(ps),
        .primary_gate_drive(pd), .secondary_gate_drive(sd), .desat_pwm_out(dso),
        .desat_pwm_reset(dsr), .irq(irq));
    ovds_analog_model i_model (.sense(sense), .pin(pin), .wdog(wdog), .level(lvl),
        .sel(dsel), .ov_out(ovc), .ds_out(dsc), .wdog_out(wdr));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic ds_exp(input logic [7:0] p, input logic s, input logic pol);
        return ((s ? 8'h80 : p) > 8'h40) ^ pol;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [8:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [8:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(rdat, e);
    endtask
    // sync path needs three edges; six leaves margin
    task automatic ana(input logic [7:0] s, input logic [7:0] p);
        @(posedge sys_clk);
        sense <= s;
        pin <= p;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        rst = 1'b1;
        pp = 1'b1;
        {wr, rd, wdog, ps, addr, wd, sense, pin} = '0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (i_dut.reg_rdata[i]) rreg(9'h0C0 + 9'(i % 5), 8'h00);
        rreg(9'h196, 8'h00);
        rreg(9'h1FF, 8'h00);
        repeat (4) begin
            rnd = lfsr(rnd);
            wreg(9'h0C1, rnd[7:0]);
            wreg(9'h196, rnd[15:8]);
            rreg(9'h0C1, rnd[7:0]);
            rreg(9'h196, rnd[15:8]);
            chk(trim, rnd[15:8]);
        end
        $display("test registers done");
        wreg(9'h0C4, 8'h03);
        wreg(9'h0C1, 8'h80);
        wreg(9'h0C0, 8'hFA);
        ana(8'h90, 8'h10);
        chk({6'h00, pd, sd}, 8'h01);
        rreg(9'h0C0, 8'h0E);
        rreg(9'h0C3, 8'h01);
        chk({7'h00, irq}, 8'h01);
        ana(8'h10, 8'h10);
        chk({6'h00, pd, sd}, 8'h02);
        rreg(9'h0C3, 8'h01);
        wreg(9'h0C3, 8'h01);
        rreg(9'h0C3, 8'h00);
        wreg(9'h0C0, 8'h01);
        ana(8'h90, 8'h10);
        chk({6'h00, pd, sd}, 8'h02);
        rreg(9'h0C3, 8'h00);
        ana(8'h10, 8'h10);
        rreg(9'h0C3, 8'h01);
        $display("test overvoltage done");
        code = 8'h00;
        wreg(9'h0C1, code);
        do begin
            code++;
            wreg(9'h0C1, code);
            ana(8'h5A, 8'h10);
            rreg(9'h0C0, {5'h00, 8'h5A > code, 2'h1});
        end while (8'h5A > code && code != 8'hFF);
        chk(lvl, 8'h5A);
        wreg(9'h0C3, 8'h01);
        $display("test calibration done");
        wreg(9'h0C4, 8'h01);
        for (int pol = 0; pol < 2; pol++) begin
            wreg(9'h0C2, {3'h0, pol[0], 4'h3});
            ana(8'h10, 8'h10);
            wreg(9'h0C3, 8'h03);
            ana(8'h10, 8'h70);
            rreg(9'h0C2, {3'h0, pol[0], 1'b0, ds_exp(8'h70, 1'b0, pol[0]), 2'h3});
            rreg(9'h0C3, 8'h02);
            chk({6'h00, irq, dso}, 8'h00);
            wreg(9'h0C3, 8'h02);
            wreg(9'h0C2, {3'h0, pol[0], 4'h8});
            ana(8'h10, 8'h10);
            chk({7'h00, dso}, {7'h00, ds_exp(8'h10, 1'b0, pol[0])});
            rreg(9'h0C3, 8'h00);
            wreg(9'h0C2, {3'h4, pol[0], 4'h8});
            ana(8'h10, 8'h10);
            rreg(9'h0C2, {3'h4, pol[0], 1'b1, ds_exp(8'h10, 1'b1, pol[0]), 2'h0});
        end
        @(posedge sys_clk) wdog <= 1'b1;
        wreg(9'h0C2, 8'h00);
        ana(8'h10, 8'h10);
        chk({7'h00, dsr}, 8'h00);
        wreg(9'h0C2, 8'h40);
        ana(8'h10, 8'h10);
        chk({7'h00, dsr}, 8'h01);
        $display("test desat done");
        finish_test();
    end
endmodule
`default_nettype wire
